//--- rtl/tdfc_pkg.sv
package tdfc_pkg;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   localparam int DATA_W = 24;
   localparam int COEF_W = 28;
   localparam int PROG_W = 36;
   localparam int PROG_DEPTH = 256;
   localparam int COEF_DEPTH = 320;
   localparam int STATE_DEPTH = 320;
   localparam int ACC_W = 58;
   localparam int PROD_W = 52;
   localparam int PM_ADDR_W = 10;
   localparam int OVR_W = 8;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // program memory bus map
   localparam logic [9:0] PM_PROG_BASE = 10'h000;
   localparam logic [9:0] PM_COEF_BASE = 10'h100;
   localparam logic [9:0] PM_COEF_END = 10'h240;
   localparam logic [9:0] PM_CTRL_ADDR = 10'h300;
   localparam logic [9:0] PM_STAT_ADDR = 10'h301;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'h0;
   localparam int STAT_EN_BIT = 0;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_PC_LSB = 2;
   localparam int STAT_OVR_LSB = 10;

   ////////////////////////////////////////////////////////////////////////////////////////////////
   localparam logic [2:0] OP_PASS = 3'h0;
   localparam logic [2:0] OP_FIR = 3'h1;
   localparam logic [2:0] OP_BQ = 3'h2;
   localparam logic [8:0] BQ_FIRST_K = 9'h004;
   localparam logic [8:0] BQ_SKIP_K = 9'h003;
   localparam logic [9:0] BQ_Y1_OFS = 10'h002;
   localparam logic signed [ACC_W-1:0] SAT_MAX = 58'sh7fffff;
   localparam logic signed [ACC_W-1:0] SAT_MIN = -58'sh800000;

   typedef struct packed {
      logic [2:0] op;
      logic last;
      logic [8:0] taps;
      logic [8:0] coef_base;
      logic [8:0] state_base;
      logic [4:0] shift;
   } tdfc_instr_t;

   typedef struct packed {
      logic valid;
      logic signed [DATA_W-1:0] data;
   } tdfc_sample_t;

   typedef struct packed {
      logic en;
      logic we;
      logic [PM_ADDR_W-1:0] addr;
      logic [PROG_W-1:0] wdata;
   } tdfc_pm_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_FETCH,
      ST_MAC,
      ST_STAGE
   } tdfc_state_t;

endpackage : tdfc_pkg

//--- rtl/tdfc_core.sv
`timescale 1ns/1ps
module tdfc_core (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // audio routing
   input tdfc_pkg::tdfc_sample_t samp_i,
   output tdfc_pkg::tdfc_sample_t samp_o,
   output tdfc_pkg::tdfc_sample_t lowdly_o,
   // program memory bus
   input tdfc_pkg::tdfc_pm_req_t pm_req_i,
   output logic [tdfc_pkg::PROG_W-1:0] pm_rdata_o,
   output logic pm_rvalid_o
);

   ////////////////////////////////////////////////////////////////////////////////////////////////
   logic [tdfc_pkg::PROG_W-1:0] prog_mem [tdfc_pkg::PROG_DEPTH];
   logic signed [tdfc_pkg::COEF_W-1:0] coef_mem [tdfc_pkg::COEF_DEPTH];
   logic signed [tdfc_pkg::DATA_W-1:0] state_mem [tdfc_pkg::STATE_DEPTH];
   tdfc_pkg::tdfc_state_t st_q;
   tdfc_pkg::tdfc_instr_t ins_q;
   logic [7:0] pc_q;
   logic [8:0] k_q;
   logic signed [tdfc_pkg::ACC_W-1:0] acc_q;
   logic signed [tdfc_pkg::DATA_W-1:0] cur_q;
   logic en_q;
   logic [tdfc_pkg::OVR_W-1:0] ovr_q;
   logic [9:0] cidx;
   logic [9:0] sidx;
   logic signed [tdfc_pkg::COEF_W-1:0] cval;
   logic signed [tdfc_pkg::DATA_W-1:0] opnd;
   logic signed [tdfc_pkg::DATA_W-1:0] shin;
   logic signed [tdfc_pkg::PROD_W-1:0] prod;
   logic signed [tdfc_pkg::DATA_W-1:0] y_stage;
   logic do_mac;
   logic wr_st;
   logic accept;
   logic emit;
   tdfc_pkg::tdfc_instr_t fetched;

   function automatic logic signed [tdfc_pkg::DATA_W-1:0] sat(
      input logic signed [tdfc_pkg::ACC_W-1:0] v);
      if (v > tdfc_pkg::SAT_MAX) begin
         return tdfc_pkg::SAT_MAX[tdfc_pkg::DATA_W-1:0];
      end else if (v < tdfc_pkg::SAT_MIN) begin
         return tdfc_pkg::SAT_MIN[tdfc_pkg::DATA_W-1:0];
      end
      return v[tdfc_pkg::DATA_W-1:0];
   endfunction : sat

   function automatic logic coef_hit(input logic [9:0] a);
      return (a >= tdfc_pkg::PM_COEF_BASE) && (a < tdfc_pkg::PM_COEF_END);
   endfunction : coef_hit

   function automatic logic prog_hit(input logic [9:0] a);
      return a[9:8] == tdfc_pkg::PM_PROG_BASE[9:8];
   endfunction : prog_hit

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // program memory bus: program store, coefficients, control and status
   // program store write
   always_ff @(posedge clk_i) begin
      if (pm_req_i.en && pm_req_i.we && prog_hit(pm_req_i.addr)) begin
         prog_mem[pm_req_i.addr[7:0]] <= pm_req_i.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (pm_req_i.en && pm_req_i.we && coef_hit(pm_req_i.addr)) begin
         coef_mem[9'(pm_req_i.addr - tdfc_pkg::PM_COEF_BASE)] <=
            pm_req_i.wdata[tdfc_pkg::COEF_W-1:0];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         en_q <= tdfc_pkg::CTRL_EN_RST;
      end else if (pm_req_i.en && pm_req_i.we && pm_req_i.addr == tdfc_pkg::PM_CTRL_ADDR) begin
         en_q <= pm_req_i.wdata[tdfc_pkg::CTRL_EN_BIT];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pm_rdata_o <= '0;
         pm_rvalid_o <= 1'b0;
      end else begin
         pm_rvalid_o <= pm_req_i.en && !pm_req_i.we;
         pm_rdata_o <= '0;
         if (pm_req_i.en && !pm_req_i.we) begin
            if (prog_hit(pm_req_i.addr)) begin
               pm_rdata_o <= prog_mem[pm_req_i.addr[7:0]];
            end else if (coef_hit(pm_req_i.addr)) begin
               pm_rdata_o <= 36'(coef_mem[9'(pm_req_i.addr - tdfc_pkg::PM_COEF_BASE)]);
            end else if (pm_req_i.addr == tdfc_pkg::PM_CTRL_ADDR) begin
               pm_rdata_o[tdfc_pkg::CTRL_EN_BIT] <= en_q;
            end else if (pm_req_i.addr == tdfc_pkg::PM_STAT_ADDR) begin
               pm_rdata_o[tdfc_pkg::STAT_EN_BIT] <= en_q;
               pm_rdata_o[tdfc_pkg::STAT_BUSY_BIT] <= st_q != tdfc_pkg::ST_IDLE;
               pm_rdata_o[tdfc_pkg::STAT_PC_LSB +: 8] <= pc_q;
               pm_rdata_o[tdfc_pkg::STAT_OVR_LSB +: tdfc_pkg::OVR_W] <= ovr_q;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // datapath decode; out-of-range coefficients read as zero, out-of-range state reads the current sample, and neither ever writes
   always_comb begin
      fetched = tdfc_pkg::tdfc_instr_t'(prog_mem[pc_q]);
      do_mac = (ins_q.op == tdfc_pkg::OP_FIR && ins_q.taps != 9'h000) ||
               ins_q.op == tdfc_pkg::OP_BQ;
      cidx = {1'b0, ins_q.coef_base} + {1'b0, k_q};
      sidx = {1'b0, ins_q.state_base} + {1'b0, k_q} - 10'h001;
      cval = (cidx < 10'(tdfc_pkg::COEF_DEPTH)) ? coef_mem[9'(cidx)] : '0;
      opnd = cur_q;
      shin = cur_q;
      if (k_q != 9'h000 && sidx < 10'(tdfc_pkg::STATE_DEPTH)) begin
         opnd = state_mem[9'(sidx)];
      end
      if (k_q > 9'h001 && sidx < 10'(tdfc_pkg::STATE_DEPTH)) begin
         shin = state_mem[9'(sidx - 10'h001)];
      end
      prod = cval * opnd;
      wr_st = st_q == tdfc_pkg::ST_MAC && k_q != 9'h000 &&
              sidx < 10'(tdfc_pkg::STATE_DEPTH) &&
              (ins_q.op == tdfc_pkg::OP_FIR || k_q != tdfc_pkg::BQ_SKIP_K);
      y_stage = do_mac ? sat(acc_q >>> ins_q.shift) : cur_q;
      accept = st_q == tdfc_pkg::ST_IDLE && samp_i.valid && en_q;
      emit = st_q == tdfc_pkg::ST_STAGE && (ins_q.last || pc_q == 8'hff);
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // sequencer; a sample arriving mid-run is dropped and counted, the count holding at 255
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= tdfc_pkg::ST_IDLE;
         ins_q <= '0;
         pc_q <= '0;
         k_q <= '0;
         acc_q <= '0;
         cur_q <= '0;
         ovr_q <= '0;
      end else begin
         if (samp_i.valid && st_q != tdfc_pkg::ST_IDLE && ovr_q != '1) begin
            ovr_q <= ovr_q + 1'b1;
         end
         case (st_q)
            tdfc_pkg::ST_IDLE: begin
               if (accept) begin
                  cur_q <= samp_i.data;
                  pc_q <= '0;
                  st_q <= tdfc_pkg::ST_FETCH;
               end
            end
            tdfc_pkg::ST_FETCH: begin
               ins_q <= fetched;
               acc_q <= '0;
               if (fetched.op == tdfc_pkg::OP_BQ) begin
                  k_q <= tdfc_pkg::BQ_FIRST_K;
                  st_q <= tdfc_pkg::ST_MAC;
               end else if (fetched.op == tdfc_pkg::OP_FIR && fetched.taps != 9'h000) begin
                  k_q <= fetched.taps - 9'h001;
                  st_q <= tdfc_pkg::ST_MAC;
               end else begin
                  k_q <= '0;
                  st_q <= tdfc_pkg::ST_STAGE;
               end
            end
            tdfc_pkg::ST_MAC: begin
               acc_q <= acc_q + 58'(prod);
               if (k_q == 9'h000) begin
                  st_q <= tdfc_pkg::ST_STAGE;
               end else begin
                  k_q <= k_q - 9'h001;
               end
            end
            tdfc_pkg::ST_STAGE: begin
               cur_q <= y_stage;
               if (emit) begin
                  st_q <= tdfc_pkg::ST_IDLE;
               end else begin
                  pc_q <= pc_q + 8'h01;
                  st_q <= tdfc_pkg::ST_FETCH;
               end
            end
            default: begin
               st_q <= tdfc_pkg::ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         for (int i = 0; i < tdfc_pkg::STATE_DEPTH; i++) begin
            state_mem[i] <= '0;
         end
      end else if (wr_st) begin
         state_mem[9'(sidx)] <= shin;
      end else if (st_q == tdfc_pkg::ST_STAGE && ins_q.op == tdfc_pkg::OP_BQ &&
                   {1'b0, ins_q.state_base} + tdfc_pkg::BQ_Y1_OFS <
                   10'(tdfc_pkg::STATE_DEPTH)) begin
         state_mem[9'({1'b0, ins_q.state_base} + tdfc_pkg::BQ_Y1_OFS)] <= y_stage;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // outputs; when disabled the sample passes straight through
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         samp_o <= '0;
         lowdly_o <= '0;
      end else begin
         lowdly_o <= samp_i;
         samp_o.valid <= emit || (samp_i.valid && !en_q && st_q == tdfc_pkg::ST_IDLE);
         samp_o.data <= emit ? y_stage : samp_i.data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////////////
   // checks
   logic [1:0] pend_q;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_q <= '0;
      end else if (accept && !emit) begin
         pend_q <= pend_q + 2'h1;
      end else if (emit && !accept) begin
         pend_q <= pend_q - 2'h1;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_coef_bound;
      st_q == tdfc_pkg::ST_MAC && cidx >= 10'(tdfc_pkg::COEF_DEPTH) |-> cval == '0;
   endproperty
   a_coef_bound: assert property (p_coef_bound) else $error("coefficient past 320 used");

   property p_fir_count;
      st_q == tdfc_pkg::ST_MAC && k_q != 9'h000 |=> st_q == tdfc_pkg::ST_MAC &&
         k_q == $past(k_q) - 9'h001;
   endproperty
   a_fir_count: assert property (p_fir_count) else $error("tap count not stepping");

   property p_bq_len;
      st_q == tdfc_pkg::ST_FETCH && fetched.op == tdfc_pkg::OP_BQ |=>
         (st_q == tdfc_pkg::ST_MAC) [*5] ##1 st_q == tdfc_pkg::ST_STAGE;
   endproperty
   a_bq_len: assert property (p_bq_len) else $error("biquad not five taps");

   property p_lowdly;
      samp_i.valid |=> lowdly_o.valid && lowdly_o.data == $past(samp_i.data);
   endproperty
   a_lowdly: assert property (p_lowdly) else $error("low-delay copy missing");

   // write, one idle cycle, then a read of the same word
   property p_prog_rd;
      pm_req_i.en && pm_req_i.we && prog_hit(pm_req_i.addr) ##1 !pm_req_i.en ##1
         pm_req_i.en && !pm_req_i.we && pm_req_i.addr == $past(pm_req_i.addr, 2) |=>
         pm_rvalid_o && pm_rdata_o == $past(pm_req_i.wdata, 3);
   endproperty
   a_prog_rd: assert property (p_prog_rd) else $error("program word readback wrong");

   property p_stat_rd;
      pm_req_i.en && !pm_req_i.we && pm_req_i.addr == tdfc_pkg::PM_STAT_ADDR |=>
         pm_rdata_o[tdfc_pkg::STAT_BUSY_BIT] == ($past(st_q) != tdfc_pkg::ST_IDLE) &&
         pm_rdata_o[tdfc_pkg::STAT_PC_LSB +: 8] == $past(pc_q);
   endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status readback wrong");

   property p_one_out;
      pend_q <= 2'h1 and (emit |-> pend_q == 2'h1);
   endproperty
   a_one_out: assert property (p_one_out) else $error("output count mismatch");

   property p_emit_out;
      emit |=> samp_o.valid && samp_o.data == $past(y_stage);
   endproperty
   a_emit_out: assert property (p_emit_out) else $error("result not delivered");

   c_fir: cover property (st_q == tdfc_pkg::ST_FETCH && fetched.op == tdfc_pkg::OP_FIR);
   c_bq: cover property (st_q == tdfc_pkg::ST_FETCH && fetched.op == tdfc_pkg::OP_BQ);
   c_emit: cover property (emit);
   c_ovr: cover property (samp_i.valid && st_q != tdfc_pkg::ST_IDLE);

endmodule : tdfc_core

//--- verification/tdfc_audio_model.sv
`timescale 1ns/1ps
module tdfc_audio_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // bench side
   input wire logic send_i,
   input wire logic [23:0] data_i,
   output logic [23:0] last_o,
   output logic [7:0] cnt_o,
   // engine side
   output tdfc_pkg::tdfc_sample_t to_dut_o,
   input tdfc_pkg::tdfc_sample_t from_dut_i
);
   logic [23:0] held_q;

   ////////////////////////////////////////////////////////////////////////////////
   // idle data flips every cycle so a stale sample can never pass for a fresh one
   assign to_dut_o.valid = send_i;
   assign to_dut_o.data = send_i ? data_i : ~held_q;

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         held_q <= '0;
      end else if (send_i) begin
         held_q <= data_i;
      end else begin
         held_q <= ~held_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // count each output
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_o <= '0;
         last_o <= '0;
      end else if (from_dut_i.valid) begin
         cnt_o <= cnt_o + 8'h01;
         last_o <= from_dut_i.data;
      end
   end
endmodule : tdfc_audio_model

//--- verification/test_tdfc_core.sv
`timescale 1ns/1ps
module test_tdfc_core;
   logic clk_i, rstn_i, send;
   logic [23:0] sdata, got_last;
   logic [7:0] got_cnt, exp_cnt;
   logic [35:0] rd;
   tdfc_pkg::tdfc_sample_t samp_i, samp_o, lowdly_o;
   tdfc_pkg::tdfc_pm_req_t pm_req_i;
   logic [35:0] pm_rdata_o;
   logic pm_rvalid_o;
   int error_cnt, comparisons;

   tdfc_core tdfc_core_inst (.clk_i(clk_i), .rstn_i(rstn_i), .samp_i(samp_i),
      .samp_o(samp_o), .lowdly_o(lowdly_o), .pm_req_i(pm_req_i),
      .pm_rdata_o(pm_rdata_o), .pm_rvalid_o(pm_rvalid_o));
   tdfc_audio_model tdfc_audio_model_inst (.clk_i(clk_i), .rstn_i(rstn_i), .send_i(send),
      .data_i(sdata), .last_o(got_last), .cnt_o(got_cnt), .to_dut_o(samp_i),
      .from_dut_i(samp_o));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_word

   task automatic chk_samp(input logic [24:0] got, input logic [24:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_samp

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results

   function automatic logic [35:0] ins(input logic [2:0] op, input logic last,
      input logic [8:0] taps, input logic [8:0] cb, input logic [8:0] sb);
      tdfc_pkg::tdfc_instr_t i;
      i = '{op, last, taps, cb, sb, 5'h00};
      return i;
   endfunction : ins

   ////////////////////////////////////////////////////////////////////////////////
   // one bus access; a read leaves its word in rd
   task automatic pm(input logic we, input logic [9:0] a, input logic [35:0] d);
      @(posedge clk_i);
      #1 pm_req_i = '{1'b1, we, a, d};
      @(posedge clk_i);
      #1 pm_req_i.en = 1'b0;
      chk_word({35'h0, pm_rvalid_o}, {35'h0, ~we}, "read strobe");
      rd = pm_rdata_o;
   endtask : pm

   task automatic send_samp(input logic [23:0] x);
      @(posedge clk_i);
      #1 send = 1'b1;
      sdata = x;
      @(posedge clk_i);
      #1 send = 1'b0;
      chk_samp(lowdly_o, {1'b1, x}, "low-delay copy");
   endtask : send_samp

   task automatic wait_out(input logic [23:0] exp);
      int k = 0;
      exp_cnt++;
      while (got_cnt !== exp_cnt && k < 40) begin
         @(posedge clk_i);
         k++;
      end
      #1;
      chk_word({28'h0, got_cnt}, {28'h0, exp_cnt}, "output count");
      chk_samp({1'b1, got_last}, {1'b1, exp}, "filtered sample");
   endtask : wait_out

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      pm(1'b0, 10'h300, 36'h0);
      chk_word(rd, 36'h0, "control after reset");
      pm(1'b0, 10'h301, 36'h0);
      chk_word(rd & 36'h3, 36'h0, "status after reset");
      pm(1'b1, 10'h0ff, 36'h9a5a5a5a5);
      pm(1'b0, 10'h0ff, 36'h0);
      chk_word(rd, 36'h9a5a5a5a5, "last program word");
      pm(1'b1, 10'h23f, 36'h008000001);
      pm(1'b0, 10'h23f, 36'h0);
      chk_word(rd, 36'hff8000001, "last coefficient");
      pm(1'b1, 10'h240, 36'h000000123);
      pm(1'b0, 10'h240, 36'h0);
      chk_word(rd, 36'h0, "past coefficient store");
      $display("test registers done");
   endtask : t_regs

   task automatic t_fir();
      pm(1'b1, 10'h100, 36'h2);
      pm(1'b1, 10'h101, 36'h3);
      pm(1'b1, 10'h000, ins(tdfc_pkg::OP_FIR, 1'b1, 9'h2, 9'h0, 9'h0));
      pm(1'b1, 10'h300, 36'h1);
      pm(1'b0, 10'h301, 36'h0);
      chk_word(rd & 36'h3, 36'h1, "enabled and idle");
      send_samp(24'h000064);
      wait_out(24'h0000c8);
      send_samp(24'h00000a);
      wait_out(24'h000140);
      $display("test fir done");
   endtask : t_fir

   task automatic t_chain();
      // biquad y = x + y1, then a one-tap fir doubling it
      for (int i = 0; i < 5; i++) begin
         pm(1'b1, 10'h108 + 10'(i), (i == 0 || i == 3) ? 36'h1 : 36'h0);
      end
      pm(1'b1, 10'h110, 36'h2);
      pm(1'b1, 10'h000, ins(tdfc_pkg::OP_BQ, 1'b0, 9'h0, 9'h8, 9'h8));
      pm(1'b1, 10'h001, ins(tdfc_pkg::OP_FIR, 1'b1, 9'h1, 9'h10, 9'h14));
      send_samp(24'h000005);
      wait_out(24'h00000a);
      send_samp(24'h000007);
      wait_out(24'h000018);
      send_samp(24'hfffffd);
      wait_out(24'h000012);
      $display("test biquad chain done");
   endtask : t_chain

   task automatic t_overrun();
      pm(1'b1, 10'h000, ins(tdfc_pkg::OP_PASS, 1'b1, 9'h0, 9'h0, 9'h0));
      @(posedge clk_i);
      #1 send = 1'b1;
      sdata = 24'h123456;
      @(posedge clk_i);
      #1 sdata = 24'h654321;
      @(posedge clk_i);
      #1 send = 1'b0;
      wait_out(24'h123456);
      repeat (10) @(posedge clk_i);
      chk_word({28'h0, got_cnt}, {28'h0, exp_cnt}, "busy sample dropped");
      pm(1'b0, 10'h301, 36'h0);
      chk_word(rd & 36'h3fc03, 36'h00401, "overrun counted");
      $display("test overrun done");
   endtask : t_overrun

   task automatic t_sat();
      // one-tap fir with shift 1, then saturation both ways, then a coefficient past the store
      pm(1'b1, 10'h120, 36'h3);
      pm(1'b1, 10'h000, ins(tdfc_pkg::OP_FIR, 1'b1, 9'h1, 9'h20, 9'h0) | 36'h1);
      send_samp(24'h00000a);
      wait_out(24'h00000f);
      pm(1'b1, 10'h120, 36'h7ffffff);
      send_samp(24'h7fffff);
      wait_out(24'h7fffff);
      send_samp(24'h800000);
      wait_out(24'h800000);
      pm(1'b1, 10'h000, ins(tdfc_pkg::OP_FIR, 1'b1, 9'h1, 9'h140, 9'h0));
      send_samp(24'h000100);
      wait_out(24'h000000);
      $display("test shift and saturation done");
   endtask : t_sat

   task automatic t_bypass();
      pm(1'b1, 10'h300, 36'h0);
      send_samp(24'h0abcde);
      chk_samp(samp_o, {1'b1, 24'h0abcde}, "disabled bypass");
      $display("test bypass done");
   endtask : t_bypass

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   initial begin
      #200000;
      error_cnt++;
      results();
   end

   initial begin
      rstn_i = 1'b0;
      send = 1'b0;
      sdata = '0;
      exp_cnt = '0;
      pm_req_i = '0;
      error_cnt = 0;
      comparisons = 0;
      repeat (12) @(posedge clk_i);
      #1;
      chk_samp(samp_o, 25'h0, "output in reset");
      rstn_i = 1'b1;
      t_regs();
      t_fir();
      t_chain();
      t_overrun();
      t_sat();
      t_bypass();
      results();
   end
endmodule : test_tdfc_core
